// file: bench/hub_port_switch_model.sv
// External power switches and overcurrent monitors of both ports.
// Assumes the hub splits each control pin into value and enable.
`timescale 1ns/1ps

module hub_port_switch_model (
   input wire logic [1:0] drive_i,
   input wire logic [1:0] drive_oe_i,
   input wire logic [1:0] fault_i,
   output logic [1:0] pin_o,
   output logic [1:0] powered_o
);
   // Wire level: hub drive, else monitor pulls low on fault, else pull-up
   assign pin_o = (drive_oe_i & drive_i) | (~drive_oe_i & ~fault_i);
   // Switch passes power only while the hub drives the pin high
   assign powered_o = drive_oe_i & drive_i;
endmodule // hub_port_switch_model

// file: bench/tb.sv
// Self-checking bench for the hub port power and strap block.
// Assumes the constants header and the switch model are compiled first.
`timescale 1ns/1ps
`include "hub_port_consts.svh"

module tb;
   logic clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, vbus = 0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, rdata, got;
   logic [1:0] plus = 2'h0, minus = 2'h0, fault = 2'h0;
   logic [1:0] pin, drv, oe, dis, powered;
   logic irq, upwr, reneg;
   int fail_count = 0, samples_checked = 0, cyc = 0, pulses;

   hub_port_power_and_straps dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .irq_o(irq), .port_plus_disable_strap_i(plus),
      .port_minus_disable_strap_i(minus), .upstream_power_sense_i(vbus),
      .upstream_power_o(upwr), .renegotiate_o(reneg),
      .port_power_overcurrent_i(pin), .port_power_overcurrent_o(drv),
      .port_power_overcurrent_oe_o(oe), .port_disabled_o(dis));
   hub_port_switch_model sw_u (.drive_i(drv), .drive_oe_i(oe),
      .fault_i(fault), .pin_o(pin), .powered_o(powered));

   // Clock and cycle ceiling
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr <= a; rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Reset with given straps, then check latch and hold
   task automatic strap_test(input logic [1:0] p, input logic [1:0] m);
      @(posedge clk_i);
      rst_n_i <= 1'b0; plus <= p; minus <= m;
      repeat (20) @(posedge clk_i);
      chk({oe, drv, dis, irq, reneg}, 8'hc0);
      rst_n_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      plus <= ~p; minus <= ~m;
      repeat (4) @(posedge clk_i);
      chk({6'h0, dis}, {6'h0, p & m});
      rd_reg(`HP_REG_STRAP, got);
      chk(got, {2'h1, p & m, m, p});
      $display("strap test done");
   endtask
   // Power request per port; port 1 disabled by straps
   task automatic power_test();
      wr_reg(`HP_REG_CTRL, 8'h03);
      repeat (2) @(posedge clk_i);
      chk({4'h0, oe, powered}, 8'h0e);
      wr_reg(`HP_REG_CTRL, 8'h00);
      repeat (2) @(posedge clk_i);
      chk({6'h0, powered}, 8'h00);
      $display("power test done");
   endtask
   // Overcurrent in sense mode, mask, irq and clear
   task automatic oc_test(input logic [7:0] mask);
      wr_reg(`HP_REG_MASK, mask);
      wr_reg(`HP_REG_CTRL, 8'h0a);
      repeat (2) @(posedge clk_i);
      chk({6'h0, oe}, 8'h01);
      fault <= 2'h2;
      repeat (5) @(posedge clk_i);
      chk({7'h0, irq}, {7'h0, mask[1]});
      rd_reg(`HP_REG_STATUS, got);
      chk(got, 8'h02);
      rd_reg(`HP_REG_LIVE, got);
      chk({7'h0, got[4]}, 8'h00);
      fault <= 2'h0;
      repeat (4) @(posedge clk_i);
      wr_reg(`HP_REG_STATUS, 8'h02);
      rd_reg(`HP_REG_STATUS, got);
      chk(got, 8'h00);
      chk({7'h0, irq}, 8'h00);
      $display("overcurrent test done");
   endtask
   // Upstream power toggle: level follows, one pulse on rise only
   task automatic vbus_test(input logic lvl);
      @(posedge clk_i);
      vbus <= lvl;
      pulses = 0;
      repeat (8) begin
         @(posedge clk_i);
         #1 pulses += reneg;
      end
      chk({7'h0, upwr}, {7'h0, lvl});
      chk(pulses[7:0], {7'h0, lvl});
      rd_reg(`HP_REG_STATUS, got);
      chk(got, 8'h04);
      wr_reg(`HP_REG_STATUS, 8'h04);
      rd_reg(`HP_REG_STATUS, got);
      chk(got, 8'h00);
      rd_reg(`HP_REG_STRAP, got);
      chk(got, 8'h5d);
      rd_reg(3'h7, got);
      chk(got, 8'h00);
      $display("vbus test done");
   endtask

   task automatic conclude();
      $display("mismatches %0d checks %0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      strap_test(2'h1, 2'h3);
      power_test();
      oc_test(8'h02);
      oc_test(8'h00);
      vbus_test(1'b1);
      vbus_test(1'b0);
      strap_test(2'h2, 2'h2);
      conclude();
   end
endmodule // tb

// file: core/hub_port_consts.svh
// Constants for the hub port power and strap block.
// Assumes inclusion by bare name from core and bench files.
`ifndef HUB_PORT_CONSTS_SVH
`define HUB_PORT_CONSTS_SVH

`define HP_ADDR_W 3
`define HP_DATA_W 8
`define HP_PORTS 2
// Register offsets
`define HP_REG_CTRL 3'h0
`define HP_REG_STATUS 3'h1
`define HP_REG_MASK 3'h2
`define HP_REG_STRAP 3'h3
`define HP_REG_LIVE 3'h4
// Control fields: power request and pin sense mode
`define HP_CTRL_PWR_LSB 0
`define HP_CTRL_MODE_LSB 2
// Status and mask fields
`define HP_ST_OC_LSB 0
`define HP_ST_VBUS 2
`define HP_EV_W 3
// Reset values
`define HP_CTRL_RST 4'h0
`define HP_MASK_RST 3'h0

`endif

// file: core/hub_port_pkg.sv
// Types for the hub port power and strap block.
// Assumes the constants header is compiled alongside.
package hub_port_pkg;
   // Strap capture sequence after reset release
   typedef enum logic [1:0] {
      cap_fill1,
      cap_fill2,
      cap_take,
      cap_hold
   } cap_state_e;
endpackage

// file: core/hub_port_power_and_straps.sv
// Port power enables, overcurrent sensing, upstream power sense and
// strap capture for a two port hub, with a small register port.
// Assumes strap and pin inputs are asynchronous to clk_i (40 MHz) and
// that power-on reset and the external reset both drive rst_n_i.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "hub_port_consts.svh"

module hub_port_power_and_straps (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [`HP_ADDR_W-1:0] addr_i,
   input wire logic [`HP_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`HP_DATA_W-1:0] rdata_o,
   output logic irq_o,
   input wire logic [1:0] port_plus_disable_strap_i,
   input wire logic [1:0] port_minus_disable_strap_i,
   input wire logic upstream_power_sense_i,
   output logic upstream_power_o,
   output logic renegotiate_o,
   input wire logic [1:0] port_power_overcurrent_i,
   output logic [1:0] port_power_overcurrent_o,
   output logic [1:0] port_power_overcurrent_oe_o,
   output logic [1:0] port_disabled_o
);

   localparam int NP = `HP_PORTS;

   logic [1:0] plus_s1, plus_s2, minus_s1, minus_s2;
   logic vbus_s1, vbus_s2, vbus_seen;
   logic [1:0] pin_s1, pin_s2;
   hub_port_pkg::cap_state_e cap, next_cap;
   logic [1:0] plus_lat, minus_lat, next_plus_lat, next_minus_lat;
   logic [1:0] power_on, next_power_on, mode, next_mode;
   logic [`HP_EV_W-1:0] status, next_status, mask, next_mask;
   logic [`HP_EV_W-1:0] events;
   logic [1:0] oc_now, disabled;
   logic next_reneg, next_seen;
   logic [`HP_DATA_W-1:0] next_rdata;

   // Two flip-flop synchronisers for every pin input
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         plus_s1 <= 2'h0;
         plus_s2 <= 2'h0;
         minus_s1 <= 2'h0;
         minus_s2 <= 2'h0;
         vbus_s1 <= 1'b0;
         vbus_s2 <= 1'b0;
         pin_s1 <= 2'h3;
         pin_s2 <= 2'h3;
      end else begin
         plus_s1 <= port_plus_disable_strap_i;
         plus_s2 <= plus_s1;
         minus_s1 <= port_minus_disable_strap_i;
         minus_s2 <= minus_s1;
         vbus_s1 <= upstream_power_sense_i;
         vbus_s2 <= vbus_s1;
         pin_s1 <= port_power_overcurrent_i;
         pin_s2 <= pin_s1;
      end
   end

   // Strap capture sequence: fill the synchronisers, take once, hold
   always_comb begin
      next_cap = cap;
      next_plus_lat = plus_lat;
      next_minus_lat = minus_lat;
      unique case (cap)
         hub_port_pkg::cap_fill1: next_cap = hub_port_pkg::cap_fill2;
         hub_port_pkg::cap_fill2: next_cap = hub_port_pkg::cap_take;
         hub_port_pkg::cap_take: begin
            next_plus_lat = plus_s2;
            next_minus_lat = minus_s2;
            next_cap = hub_port_pkg::cap_hold;
         end
         hub_port_pkg::cap_hold: next_cap = hub_port_pkg::cap_hold;
      endcase
   end

   // Reset puts capture back at the start and clears the straps
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cap <= hub_port_pkg::cap_fill1;
         plus_lat <= 2'h0;
         minus_lat <= 2'h0;
      end else begin
         cap <= next_cap;
         plus_lat <= next_plus_lat;
         minus_lat <= next_minus_lat;
      end
   end

   // Port disable from paired straps, valid once capture is done
   assign disabled = plus_lat & minus_lat;
   assign port_disabled_o = disabled;

   // Overcurrent seen only while the pin is released in sense mode
   assign oc_now = mode & ~pin_s2;

   // Upstream power level and its change event
   assign upstream_power_o = vbus_s2;
   assign events = {vbus_s2 ^ vbus_seen, oc_now};

   // Control, status and mask next values
   always_comb begin
      next_power_on = power_on;
      next_mode = mode;
      next_mask = mask;
      next_status = status;
      if (wr_i && addr_i == `HP_REG_CTRL) begin
         next_power_on = wdata_i[`HP_CTRL_PWR_LSB +: NP];
         next_mode = wdata_i[`HP_CTRL_MODE_LSB +: NP];
      end
      if (wr_i && addr_i == `HP_REG_MASK) begin
         next_mask = wdata_i[`HP_EV_W-1:0];
      end
      if (wr_i && addr_i == `HP_REG_STATUS) begin
         next_status = status & ~wdata_i[`HP_EV_W-1:0];
      end
      next_status = next_status | events;
      next_power_on = next_power_on & ~oc_now & ~disabled;
      // A vbus rise renegotiates and any toggle sets status; straps and ports stay as they are
      next_seen = vbus_s2;
      next_reneg = vbus_s2 & ~vbus_seen;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {mode, power_on} <= `HP_CTRL_RST;
         mask <= `HP_MASK_RST;
         status <= 3'h0;
         vbus_seen <= 1'b0;
         renegotiate_o <= 1'b0;
      end else begin
         power_on <= next_power_on;
         mode <= next_mode;
         mask <= next_mask;
         status <= next_status;
         vbus_seen <= next_seen;
         renegotiate_o <= next_reneg;
      end
   end

   // Control pins: drive power level in output mode, release in sense mode
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_pin
         assign port_power_overcurrent_o[g] = power_on[g];
         assign port_power_overcurrent_oe_o[g] = ~mode[g];
      end
   endgenerate

   assign irq_o = |(status & mask);

   // Read data, standing only in the cycle after the read strobe
   always_comb begin
      next_rdata = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            `HP_REG_CTRL: next_rdata = {4'h0, mode, power_on};
            `HP_REG_STATUS: next_rdata = {5'h00, status};
            `HP_REG_MASK: next_rdata = {5'h00, mask};
            `HP_REG_STRAP: next_rdata = {1'b0,
               cap == hub_port_pkg::cap_hold, disabled, minus_lat, plus_lat};
            `HP_REG_LIVE: next_rdata = {3'h0, power_on, pin_s2, vbus_s2};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // Checks; the release edge itself still sees the block in reset
   strap_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      cap == hub_port_pkg::cap_hold |=> $stable(plus_lat) &&
      $stable(minus_lat))
      else $error("straps changed after capture");

   strap_take_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      cap == hub_port_pkg::cap_take |=> plus_lat == $past(plus_s2) &&
      minus_lat == $past(minus_s2))
      else $error("straps not taken from synchroniser");

   capture_seq_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      rst_n_i && cap == hub_port_pkg::cap_fill1 |=>
      cap == hub_port_pkg::cap_fill2 ##1 cap == hub_port_pkg::cap_take ##1
      cap == hub_port_pkg::cap_hold)
      else $error("capture sequence broken");

   port_off_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      (plus_lat[0] && minus_lat[0]) |-> !port_power_overcurrent_o[0])
      else $error("disabled port powered");

   vbus_follow_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $past(rst_n_i, 2) |->
      upstream_power_o == $past(upstream_power_sense_i, 2))
      else $error("upstream power not following sense");

   renegotiate_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(upstream_power_o) |=> renegotiate_o ##1 !renegotiate_o)
      else $error("renegotiate pulse wrong");

   power_on_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      wr_i && addr_i == `HP_REG_CTRL && wdata_i[0] && !wdata_i[2] &&
      !disabled[0] |=> port_power_overcurrent_o[0] &&
      port_power_overcurrent_oe_o[0])
      else $error("port 1 not powered after write");

   oc_react_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      mode[1] && !pin_s2[1] |=> status[1] && !power_on[1])
      else $error("overcurrent not handled");

   oc_irq_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      oc_now[0] && mask[0] && !(wr_i && addr_i == `HP_REG_MASK) |=>
      irq_o)
      else $error("overcurrent interrupt missing");

endmodule // hub_port_power_and_straps
